// ==== rtl/eqr_pkg.sv ====
// Constants, register map and state type for the equalizer register bank
// ==========================================================================
// Contract
// - Global control bit 6 high puts the whole chip to sleep while set.
// - Global control bit 1 selects loss-of-signal range; high raises sensitivity.
// - Global control bit 0 makes channel B follow all channel A settings; the code copies only the channel A control byte at 0x02 onto channel B.
// - Channel A control bit 7 powers down channel A input stages.
// - Channel A control bit 6 powers down channel A output driver and buffer.
// - Channel A control bit 5 powers down channel A signal detector.
// - Channel A control bit 4 high disables offset cancellation; low keeps it active.
// - Channel A control bit 2 high enables channel A automatic output squelch.
// - Channel A control bit 1 high inverts channel A output polarity.
// - Channel A control bit 0 high blocks output data, common mode kept.
// - Channel A input bits 7..4 select bandwidth; 0000 highest, 1111 lowest.
// - Channel A input bit n high switches equalizer filter stage n off.
// - Status at 0x0E: bit 1 channel B loss, bit 0 channel A loss.
// - Channel B control at 0x06 repeats channel A control layout and behaviour.
// ==========================================================================
package eqr_pkg;

  // ========================================================================
  // Register map
  localparam logic [7:0] ADDR_GLOBAL  = 8'h00;
  localparam logic [7:0] ADDR_RSVD1   = 8'h01;
  localparam logic [7:0] ADDR_CTL_A   = 8'h02;
  localparam logic [7:0] ADDR_IN_A    = 8'h03;
  localparam logic [7:0] ADDR_CTL_B   = 8'h06;
  localparam logic [7:0] ADDR_STATUS  = 8'h0E;
  localparam logic [7:0] ADDR_RSVD15  = 8'h0F;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_GLOBAL   = 8'h00;
  localparam logic [7:0] RST_CTL      = 8'h00;
  localparam logic [7:0] RST_IN       = 8'h00;
  localparam logic [7:0] GC_MASK      = 8'h43;
  localparam logic [7:0] CTL_MASK     = 8'hF7;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // ========================================================================
  // Field positions
  localparam int GC_SWRST    = 7;
  localparam int GC_SLEEP    = 6;
  localparam int GC_RANGE    = 1;
  localparam int GC_FOLLOW   = 0;
  localparam int CTL_IN_OFF  = 7;
  localparam int CTL_OUT_OFF = 6;
  localparam int CTL_DET_OFF = 5;
  localparam int CTL_OC_OFF  = 4;
  localparam int CTL_SQUELCH = 2;
  localparam int CTL_INVERT  = 1;
  localparam int CTL_BLOCK   = 0;
  localparam int BW_HI       = 7;
  localparam int BW_LO       = 4;
  localparam int EQ_HI       = 3;
  localparam int EQ_LO       = 0;
  localparam int ST_LOS_A    = 0;
  localparam int ST_LOS_B    = 1;

  // ========================================================================
  // Serial link
  localparam logic [3:0] DEV_BASE_DEF = 4'h5;  // Arbitrary upper address bits
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam logic [7:0] PTR_ONE      = 8'h01;
  localparam logic [3:0] PIN_IDLE     = 4'h3;  // Lines idle high, detectors clear
  localparam int PIN_SCL   = 0;
  localparam int PIN_SDA   = 1;
  localparam int PIN_LOS_A = 2;
  localparam int PIN_LOS_B = 3;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_REG   = 9'h008,
    ST_RACKW = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_MACK  = 9'h100
  } eqr_state_t;

endpackage

// ==== rtl/eqr_regs.sv ====
// Two-wire serial slave and configuration/status registers of the equalizer
`timescale 1ns/1ns
module eqr_regs #(
  parameter logic [3:0] DEV_BASE = eqr_pkg::DEV_BASE_DEF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] addr_sel,
  input  wire logic [1:0] los_det,
  output logic            chip_sleep,
  output logic            signal_loss_range_sel,
  output logic            first_channel_follow_mode,
  output logic [1:0]      input_stage_shutdown,
  output logic [1:0]      output_driver_shutdown,
  output logic [1:0]      signal_detector_shutdown,
  output logic [1:0]      offset_cancel_inhibit,
  output logic [1:0]      squelch_enable,
  output logic [1:0]      output_invert,
  output logic [1:0]      output_block,
  output logic [3:0]      chan_a_bandwidth_sel,
  output logic [3:0]      chan_a_filter_stage_off
);
  import eqr_pkg::*;

  // ========================================================================
  // Pin synchronisers
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_p_q;
  logic [6:0] dev_addr_q;
  eqr_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic       rw_q, nack_q;
  logic [7:0] global_q, ctl_a_q, in_a_q, ctl_b_q;
  logic [7:0] ctl_b_eff;
  logic       scl_rise, scl_fall, start_det, stop_det, wr_stb, swrst;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s1_q <= PIN_IDLE;
      pin_s2_q <= PIN_IDLE;
      pin_s3_q <= PIN_IDLE;
      pin_f_q  <= PIN_IDLE;
      pin_p_q  <= PIN_IDLE;
    end else begin
      pin_s1_q <= {los_det, sda_in, scl_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
      pin_p_q  <= pin_f_q;
    end
  end

  // Address strap caught while reset is held; straps are static
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dev_addr_q <= {DEV_BASE, addr_sel};
    end
  end

  // Bus conditions from the filtered lines
  assign scl_rise  = pin_f_q[PIN_SCL] & ~pin_p_q[PIN_SCL];
  assign scl_fall  = ~pin_f_q[PIN_SCL] & pin_p_q[PIN_SCL];
  assign start_det = pin_f_q[PIN_SCL] & pin_p_q[PIN_SCL] & pin_p_q[PIN_SDA] & ~pin_f_q[PIN_SDA];
  assign stop_det  = pin_f_q[PIN_SCL] & pin_p_q[PIN_SCL] & ~pin_p_q[PIN_SDA] & pin_f_q[PIN_SDA];

  // ========================================================================
  // Read data
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = ZERO_BYTE;
    unique case (a)
      ADDR_GLOBAL: r = global_q;
      ADDR_CTL_A:  r = ctl_a_q;
      ADDR_IN_A:   r = in_a_q;
      ADDR_CTL_B:  r = ctl_b_q;
      ADDR_STATUS: begin
        r[ST_LOS_A] = pin_f_q[PIN_LOS_A];  // Live detector state
        r[ST_LOS_B] = pin_f_q[PIN_LOS_B];
      end
      default:     r = ZERO_BYTE;          // Reserved and unused read zero
    endcase
    return r;
  endfunction

  // ========================================================================
  // Serial slave: sample on SCL rise, change drive on SCL fall
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
      shift_q <= ZERO_BYTE;
      tx_q    <= ZERO_BYTE;
      ptr_q   <= ZERO_BYTE;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_ADDR;                  // Repeated start also lands here
      cnt_q   <= CNT_ZERO;
    end else if (scl_rise) begin
      unique case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_q <= {shift_q[6:0], pin_f_q[PIN_SDA]};
          cnt_q   <= cnt_q + CNT_ONE;
        end
        ST_RDATA: cnt_q <= cnt_q + CNT_ONE;
        ST_MACK:  nack_q <= pin_f_q[PIN_SDA];
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        ST_ADDR: if (cnt_q == BYTE_BITS) begin
          cnt_q <= CNT_ZERO;
          rw_q  <= shift_q[0];
          // Foreign address: stay silent until the next start
          state_q <= (shift_q[7:1] == dev_addr_q) ? ST_AACK : ST_IDLE;
        end
        ST_AACK: if (rw_q) begin
          tx_q    <= rd_byte(ptr_q);
          ptr_q   <= ptr_q + PTR_ONE;
          state_q <= ST_RDATA;
        end else begin
          state_q <= ST_REG;
        end
        ST_REG: if (cnt_q == BYTE_BITS) begin
          cnt_q   <= CNT_ZERO;
          ptr_q   <= shift_q;
          state_q <= ST_RACKW;
        end
        ST_RACKW: state_q <= ST_WDATA;
        ST_WDATA: if (cnt_q == BYTE_BITS) begin
          cnt_q   <= CNT_ZERO;
          ptr_q   <= ptr_q + PTR_ONE;      // Auto-increment for bursts
          state_q <= ST_WACK;
        end
        ST_WACK: state_q <= ST_WDATA;
        ST_RDATA: if (cnt_q == BYTE_BITS) begin
          cnt_q   <= CNT_ZERO;
          state_q <= ST_MACK;
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
        ST_MACK: if (nack_q) begin
          state_q <= ST_IDLE;
        end else begin
          tx_q    <= rd_byte(ptr_q);
          ptr_q   <= ptr_q + PTR_ONE;
          state_q <= ST_RDATA;
        end
        default: ;
      endcase
    end
  end

  // Open drain: only ever pull low, acks and zero data bits
  assign sda_out = 1'b0;
  assign sda_oe  = (state_q == ST_AACK) || (state_q == ST_RACKW) || (state_q == ST_WACK) ||
                   ((state_q == ST_RDATA) && !tx_q[7]);

  // ========================================================================
  // Register file
  assign wr_stb = scl_fall && !stop_det && !start_det && (state_q == ST_WDATA) &&
                  (cnt_q == BYTE_BITS);
  assign swrst  = wr_stb && (ptr_q == ADDR_GLOBAL) && shift_q[GC_SWRST];

  // Software reset clears every register and reads back as zero
  always_ff @(posedge clk) begin
    if (!nrst || swrst) begin
      global_q <= RST_GLOBAL;
      ctl_a_q  <= RST_CTL;
      in_a_q   <= RST_IN;
      ctl_b_q  <= RST_CTL;
    end else if (wr_stb) begin
      unique case (ptr_q)
        ADDR_GLOBAL: global_q <= shift_q & GC_MASK;
        ADDR_CTL_A:  ctl_a_q  <= shift_q & CTL_MASK;
        ADDR_IN_A:   in_a_q   <= shift_q;
        ADDR_CTL_B:  ctl_b_q  <= shift_q & CTL_MASK;
        default: ;                         // Status and reserved drop writes
      endcase
    end
  end

  // ========================================================================
  // Control outputs; tracking mode copies channel A onto channel B
  assign ctl_b_eff = global_q[GC_FOLLOW] ? ctl_a_q : ctl_b_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      chip_sleep                <= 1'b0;
      signal_loss_range_sel     <= 1'b0;
      first_channel_follow_mode <= 1'b0;
    end else begin
      chip_sleep                <= global_q[GC_SLEEP];
      signal_loss_range_sel     <= global_q[GC_RANGE];
      first_channel_follow_mode <= global_q[GC_FOLLOW];
    end
  end

  // Per-channel controls; index 0 is channel A, 1 is channel B
  always_ff @(posedge clk) begin
    if (!nrst) begin
      input_stage_shutdown     <= 2'h0;
      output_driver_shutdown   <= 2'h0;
      signal_detector_shutdown <= 2'h0;
      offset_cancel_inhibit    <= 2'h0;
      squelch_enable           <= 2'h0;
      output_invert            <= 2'h0;
      output_block             <= 2'h0;
    end else begin
      input_stage_shutdown     <= {ctl_b_eff[CTL_IN_OFF], ctl_a_q[CTL_IN_OFF]};
      output_driver_shutdown   <= {ctl_b_eff[CTL_OUT_OFF], ctl_a_q[CTL_OUT_OFF]};
      signal_detector_shutdown <= {ctl_b_eff[CTL_DET_OFF], ctl_a_q[CTL_DET_OFF]};
      offset_cancel_inhibit    <= {ctl_b_eff[CTL_OC_OFF], ctl_a_q[CTL_OC_OFF]};
      squelch_enable           <= {ctl_b_eff[CTL_SQUELCH], ctl_a_q[CTL_SQUELCH]};
      output_invert            <= {ctl_b_eff[CTL_INVERT], ctl_a_q[CTL_INVERT]};
      output_block             <= {ctl_b_eff[CTL_BLOCK], ctl_a_q[CTL_BLOCK]};
    end
  end

  // Channel A input settings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chan_a_bandwidth_sel    <= RST_IN[BW_HI:BW_LO];
      chan_a_filter_stage_off <= RST_IN[EQ_HI:EQ_LO];
    end else begin
      chan_a_bandwidth_sel    <= in_a_q[BW_HI:BW_LO];
      chan_a_filter_stage_off <= in_a_q[EQ_HI:EQ_LO];
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Global writes reach the pins two edges after the strobe
  a_sleep_write: assert property (
    wr_stb && ptr_q == ADDR_GLOBAL && !shift_q[GC_SWRST]
    |=> ##1 chip_sleep == $past(shift_q[GC_SLEEP], 2))
    else $error("sleep not applied");
  a_sleep_hold: assert property (
    chip_sleep == $past(global_q[GC_SLEEP]))
    else $error("sleep not held");
  a_range_write: assert property (
    wr_stb && ptr_q == ADDR_GLOBAL && !shift_q[GC_SWRST]
    |=> ##1 signal_loss_range_sel == $past(shift_q[GC_RANGE], 2))
    else $error("range select not applied");
  a_range_hold: assert property (
    signal_loss_range_sel == $past(global_q[GC_RANGE]))
    else $error("range select not held");

  // Tracking: channel B invert, block and input-stage pins must mirror channel A one edge later
  a_follow_copy: assert property (
    global_q[GC_FOLLOW] && $stable(ctl_a_q)
    |=> output_invert[1] == output_invert[0] && output_block[1] == output_block[0]
        && input_stage_shutdown[1] == input_stage_shutdown[0])
    else $error("channel B not following A");

  // Channel A control and input settings
  a_ctl_a_map: assert property (
    wr_stb && ptr_q == ADDR_CTL_A
    |=> ##1 {input_stage_shutdown[0], output_driver_shutdown[0], signal_detector_shutdown[0],
             offset_cancel_inhibit[0], squelch_enable[0], output_invert[0], output_block[0]}
        == {$past(shift_q[7:4], 2), $past(shift_q[2:0], 2)})
    else $error("channel A control mismatch");
  a_ctl_a_low: assert property (
    ctl_a_q[CTL_SQUELCH] && ctl_a_q[CTL_BLOCK] && $stable(ctl_a_q)
    |=> squelch_enable[0] && output_block[0] && !ctl_a_q[3]
        && output_invert[0] == $past(ctl_a_q[CTL_INVERT]))
    else $error("channel A low bits wrong");
  a_input_map: assert property (
    wr_stb && ptr_q == ADDR_IN_A
    |=> ##1 {chan_a_bandwidth_sel, chan_a_filter_stage_off} == $past(shift_q, 2))
    else $error("input settings mismatch");
  a_filter_hold: assert property (
    chan_a_filter_stage_off == $past(in_a_q[EQ_HI:EQ_LO]))
    else $error("filter stage controls not held");

  // Own channel B settings; compared with the register one edge back
  a_ctl_b_own: assert property (
    !global_q[GC_FOLLOW]
    |=> input_stage_shutdown[1] == $past(ctl_b_q[CTL_IN_OFF])
        && output_block[1] == $past(ctl_b_q[CTL_BLOCK])
        && output_invert[1] == $past(ctl_b_q[CTL_INVERT]))
    else $error("channel B control mismatch");

  // Status byte, ignored writes and software reset
  a_status_load: assert property (
    state_q == ST_AACK && scl_fall && rw_q && ptr_q == ADDR_STATUS
    && !stop_det && !start_det |=> tx_q[7:2] == 6'h00
    && tx_q[ST_LOS_A] == $past(pin_f_q[PIN_LOS_A])
    && tx_q[ST_LOS_B] == $past(pin_f_q[PIN_LOS_B]))
    else $error("status byte wrong");
  a_rsvd_ignored: assert property (
    wr_stb && (ptr_q == ADDR_STATUS || ptr_q == ADDR_RSVD1 || ptr_q == ADDR_RSVD15)
    |=> $stable(global_q) && $stable(ctl_a_q) && $stable(ctl_b_q) && $stable(in_a_q))
    else $error("reserved write took effect");
  a_swrst_clear: assert property (
    swrst |=> ctl_a_q == RST_CTL && global_q == RST_GLOBAL && in_a_q == RST_IN
    && ctl_b_q == RST_CTL)
    else $error("software reset incomplete");

  c_write_ctl_a: cover property (wr_stb && ptr_q == ADDR_CTL_A);
  c_read_status: cover property (state_q == ST_RDATA && ptr_q == ADDR_RSVD15);
  c_follow_on:   cover property (first_channel_follow_mode && input_stage_shutdown == 2'h3);
  c_sleep:       cover property (chip_sleep);
  c_soft_reset:  cover property (swrst);

endmodule

// ==== verif/eqr_host.sv ====
// Two-wire serial host model that drives the equalizer register bank
`timescale 1ns/1ns
module eqr_host (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  // Clocks per SCL high phase, half of each low phase; the pin filter needs at least 8
  localparam int HALF = 10;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ==========================================================================
  // Bit level
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Data moves mid-low only, so no false start or stop is seen
  task automatic put_bit(input logic b, output logic seen);
    step(HALF);
    sda_low = ~b;
    step(HALF);
    scl = 1'b1;
    step(HALF);
    seen = sda_wire;
    scl = 1'b0;
  endtask

  // Start or repeated start: SDA falls while SCL is high
  task automatic start_cond();
    step(HALF);
    sda_low = 1'b0;
    step(HALF);
    scl = 1'b1;
    step(HALF);
    sda_low = 1'b1;
    step(HALF);
    scl = 1'b0;
  endtask

  // Stop: SDA rises while SCL is high, line left released
  task automatic stop_cond();
    step(HALF);
    sda_low = 1'b1;
    step(HALF);
    scl = 1'b1;
    step(HALF);
    sda_low = 1'b0;
    step(HALF);
  endtask

  // ==========================================================================
  // Byte level, MSB first, ninth clock carries the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    acked = ~s;
  endtask

  task automatic get_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b = {b[6:0], s};
    end
    put_bit(1'b1, s);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic acked);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(ra, a1);
    send_byte(d, a2);
    stop_cond();
    acked = a0 & a1 & a2;
  endtask

  // Single read ends with a refused acknowledge from the host
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d);
    logic a;
    start_cond();
    send_byte({dev, 1'b0}, a);
    send_byte(ra, a);
    start_cond();
    send_byte({dev, 1'b1}, a);
    get_byte(d);
    stop_cond();
  endtask
endmodule

// ==== verif/equalizer_config_status_regs_bench.sv ====
// Self-checking bench for the equalizer configuration and status registers
`timescale 1ns/1ns
module equalizer_config_status_regs_bench;
  import eqr_pkg::*;
  localparam logic [2:0] STRAP_A = 3'h2;  // Straps before and after the mid-run reset
  localparam logic [2:0] STRAP_B = 3'h5;
  logic       [2:0] strap;
  wire logic  [6:0] dev;
  logic             clk;
  logic             nrst;
  logic       [1:0] los_det;
  logic             scl;
  logic             sda_low;
  logic             sda_out;
  logic             sda_oe;
  wire logic        sda_wire;
  wire logic [24:0] outs;
  logic       [7:0] g, ca, ia, cb;
  int               num_errors;
  int               n_tests;
  // Rows: address, written byte, expected read-back
  logic      [23:0] rows [9] = '{24'h02FFF7, 24'h03A5A5, 24'h065A52, 24'h004242, 24'h01FF00,
                                  24'h0FFF00, 24'h0EFF00, 24'h09FF00, 24'h0A3300};

  // Open drain with pull-up: released means high
  assign sda_wire = ~sda_low & ~(sda_oe & ~sda_out);
  assign dev      = {DEV_BASE_DEF, strap};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  eqr_host host_u (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

  eqr_regs dut_u (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(strap), .los_det(los_det), .chip_sleep(outs[24]),
    .signal_loss_range_sel(outs[23]), .first_channel_follow_mode(outs[22]),
    .input_stage_shutdown(outs[21:20]), .output_driver_shutdown(outs[19:18]),
    .signal_detector_shutdown(outs[17:16]), .offset_cancel_inhibit(outs[15:14]),
    .squelch_enable(outs[13:12]), .output_invert(outs[11:10]), .output_block(outs[9:8]),
    .chan_a_bandwidth_sel(outs[7:4]), .chan_a_filter_stage_off(outs[3:0]));

  // ==========================================================================
  // Expected outputs; follow mode makes channel B copy channel A
  function automatic logic [24:0] exp_outs(input logic [7:0] gc, a, ai, b0);
    logic [7:0] b;
    b = gc[0] ? a : b0;
    return {gc[6], gc[1], gc[0], b[7], a[7], b[6], a[6], b[5], a[5], b[4], a[4],
            b[2], a[2], b[1], a[1], b[0], a[0], ai};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ack;
    host_u.write_reg(dev, ra, d, ack);
    check(ack, 1);
    host_u.step(4);
  endtask

  task automatic rd_check(input logic [7:0] ra, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(dev, ra, d);
    check(d, exp);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic ack;
    logic [7:0] bw [2];
    num_errors = 0;
    bw = '{8'h0F, 8'hF0};
    n_tests = 0;
    nrst = 1'b0;
    strap = STRAP_A;
    los_det = 2'b00;
    {g, ca, ia, cb} = '0;
    repeat (12) @(posedge clk);
    #5 nrst = 1'b1;
    host_u.step(4);
    check(outs, 25'h0);
    foreach (rows[i]) begin
      rd_check(rows[i][23:16], 8'h00);
      wr(rows[i][23:16], rows[i][15:8]);
      rd_check(rows[i][23:16], rows[i][7:0]);
      case (rows[i][23:16])
        8'h00: g = rows[i][7:0];
        8'h02: ca = rows[i][7:0];
        8'h03: ia = rows[i][7:0];
        8'h06: cb = rows[i][7:0];
        default: ;
      endcase
      check(outs, exp_outs(g, ca, ia, cb));
    end
    // Follow mode on and sleep cleared by the same write
    g = 8'h01;
    wr(8'h00, g);
    check(outs, exp_outs(g, ca, ia, cb));
    // Bandwidth and filter stage extremes
    foreach (bw[j]) begin
      ia = bw[j];
      wr(8'h03, ia);
      check(outs, exp_outs(g, ca, ia, cb));
    end
    // Live detector levels in the status register
    for (int k = 1; k < 4; k++) begin
      los_det = k[1:0];
      host_u.step(10);
      rd_check(8'h0E, {6'h00, k[1:0]});
    end
    // Foreign device address is not acknowledged and changes nothing
    host_u.write_reg(dev ^ 7'h01, 8'h02, 8'h00, ack);
    check(ack, 0);
    rd_check(8'h02, ca);
    // Reset in mid-run clears every control output and takes a new strap
    nrst = 1'b0;
    strap = STRAP_B;
    host_u.step(12);
    nrst = 1'b1;
    host_u.step(4);
    check(outs, 25'h0);
    rd_check(8'h03, 8'h00);
    // The address from before the reset is refused and changes nothing
    host_u.write_reg({DEV_BASE_DEF, STRAP_A}, 8'h02, 8'hFF, ack);
    check(ack, 0);
    rd_check(8'h02, 8'h00);
    // Software reset clears registers and control outputs alike
    {g, ca, ia, cb} = {8'h00, 8'hF7, 8'h5A, 8'h00};
    wr(8'h02, 8'hFF);
    wr(8'h03, ia);
    check(outs, exp_outs(g, ca, ia, cb));
    wr(8'h00, 8'h80);
    check(outs, 25'h0);
    rd_check(8'h03, 8'h00);
    give_verdict();
  end
endmodule
